// file: src/switch_snoop_qos_vlan_regs.v
// global snooping, mirroring, qos and vlan entry staging registers
// Behaviour
// - ipv4 snoop enable bit 6 sends every igmp packet to host port
// - ipv6 snoop enable bit 2 sends every mld packet to host port
// - option one: next header 43,44,50,51,60, also behind hop-by-hop
// - option zero: next header 1 or 58, also behind hop-by-hop
// - sniff mode one: source and destination both must match
// - sniff mode zero: source or destination match suffices
// - mirroring needs per-port ingress mirror enable as well
// - wred map: red 5:4=11b, yellow 3:2=10b, green 1:0=01b
// - bits 7:6 (reset 10b) map two-bit priority into two queues
// - 00: 3 high; 10: 2-3 high; 11: 1-3 high; 01 unused
// - discard bit 1 (reset 1) restricts frames to member ports
// - discard clear leaves single-destination frames unrestricted
// - mirrored single-destination frame with no member destination port is dropped by the restriction
// - entry word0 bit 31 marks the vlan entry valid
// - forward option bit 27 selects entry forward map or member-filtered destination map
// - priority in 26:24, spanning instance index in 14:12
// - 7-bit filter group id in bits 6:0
// - untag map bits 6:0 for ports 7..1, one strips the tag
// - forward map bits 6:0 for ports 7..1, used only with option set
// - action code: 00 nop, 01 write, 10 read, 11 clear all
`timescale 1ns/1ps
`default_nettype none
`include "switch_snoop_regs.vh"
module switch_snoop_qos_vlan_regs (
	input  wire                 clk,
	input  wire                 rst,
	input  wire [`ADDR_W-1:0]   regAddr,
	input  wire                 regWrEn,
	input  wire [7:0]           regWrData,
	input  wire                 regRdEn,
	output reg  [7:0]           regRdData,
	output reg                  regRdValid,
	input  wire                 tableDone,
	input  wire                 tableRdLoad,
	input  wire [31:0]          tableRdWord0,
	input  wire [6:0]           tableRdUntag,
	input  wire [6:0]           tableRdForward,
	output reg                  tableActionStrobe,
	output reg  [1:0]           tableActionCode,
	output reg  [11:0]          tableIndex,
	output wire [31:0]          stageWord0,
	output wire [6:0]           stageUntag,
	output wire [6:0]           stageForward,
	input  wire                 frameValid,
	input  wire                 frameIsIgmp,
	input  wire                 frameIsIpv6,
	input  wire [7:0]           nextHeader,
	input  wire [7:0]           hopNextHeader,
	input  wire                 ingressMirrorEn,
	input  wire                 srcPortMatch,
	input  wire                 dstPortMatch,
	input  wire [1:0]           regenPriority,
	input  wire                 singleDest,
	input  wire [6:0]           destPortMap,
	input  wire [6:0]           memberPortMap,
	input  wire                 vlanHit,
	input  wire [6:0]           lookupPortMap,
	output reg                  resultValid,
	output reg                  toHost,
	output reg                  mirror,
	output reg                  highQueue,
	output reg  [6:0]           egressPortMap,
	output reg                  dropFrame,
	output reg  [1:0]           redCode,
	output reg  [1:0]           yellowCode,
	output reg  [1:0]           greenCode
);
	// register fields, reserved bits are never stored
	reg        igmpSnoopEn_reg;
	reg        ipv6SnoopMatchOption_reg;
	reg        mldSnoopEn_reg;
	reg        sniffAndMode_reg;
	reg [1:0]  redCode_reg;
	reg [1:0]  yellowCode_reg;
	reg [1:0]  greenCode_reg;
	reg [1:0]  twoQueuePriorityMap_reg;
	reg        membershipDiscard_reg;
	reg        entryValid_reg;
	reg        forwardOptionBit_reg;
	reg [2:0]  entryPriority_reg;
	reg [2:0]  spanningInstanceIndex_reg;
	reg [6:0]  filterGroupId_reg;
	reg [6:0]  untagMap_reg;
	reg [6:0]  forwardMap_reg;
	reg [11:0] vlanIndex_reg;
	reg        actionBusy_reg;
	reg [1:0]  actionCode_reg;

	wire [6:0] filteredMap;
	wire       snoopHit;
	wire       mirrorHit;
	wire       queueHigh;
	wire       dropHit;

	// word0 image of the staged entry, reserved bits held at zero
	assign stageWord0 = {entryValid_reg, 3'h0, forwardOptionBit_reg,
		entryPriority_reg, 9'h000, spanningInstanceIndex_reg, 5'h00,
		filterGroupId_reg};
	assign stageUntag = untagMap_reg;
	assign stageForward = forwardMap_reg;

	// 32-bit registers are big-endian: base+0 holds bits 31:24
	function [7:0] readByte;
		input [`ADDR_W-1:0] a;
		reg   [31:0]        w;
		begin
			w = 32'h00000000;
			case ({a[`ADDR_W-1:2], 2'b00})
			`ADDR_MIRROR_CTRL: w = {1'b0, igmpSnoopEn_reg, 2'b00,
				ipv6SnoopMatchOption_reg, mldSnoopEn_reg, 1'b0,
				sniffAndMode_reg, 24'h000000};
			`ADDR_WRED_MAP: w = {2'b00, redCode_reg, yellowCode_reg,
				greenCode_reg, 24'h000000};
			`ADDR_QUEUE_CTRL: w = {24'h000000, twoQueuePriorityMap_reg,
				4'h0, membershipDiscard_reg, 1'b0};
			`ADDR_VLAN_WORD0: w = stageWord0;
			`ADDR_VLAN_WORD1: w = {25'h0000000, untagMap_reg};
			`ADDR_VLAN_WORD2: w = {25'h0000000, forwardMap_reg};
			`ADDR_VLAN_INDEX: w = {4'h0, vlanIndex_reg, actionBusy_reg,
				5'h00, actionCode_reg, 8'h00};
			default: w = 32'h00000000; // unmapped reads zero
			endcase
			case (a[1:0])
			2'b00:   readByte = w[31:24];
			2'b01:   readByte = w[23:16];
			2'b10:   readByte = w[15:8];
			default: readByte = w[7:0];
			endcase
		end
	endfunction

	function isAddr;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] b;
		begin
			isAddr = (a == b);
		end
	endfunction

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			regRdData <= 8'h00;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regRdEn;
			regRdData <= regRdEn ? readByte(regAddr) : regRdData;
		end
	end

	// writes touch only named fields, reserved bits drop away
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			igmpSnoopEn_reg <= 1'b0;
			ipv6SnoopMatchOption_reg <= 1'b0;
			mldSnoopEn_reg <= 1'b0;
			sniffAndMode_reg <= 1'b0;
			redCode_reg <= `WRED_RED_RST;
			yellowCode_reg <= `WRED_YEL_RST;
			greenCode_reg <= `WRED_GRN_RST;
			twoQueuePriorityMap_reg <= `QM_MAP_RST;
			membershipDiscard_reg <= `QM_DISCARD_RST;
			vlanIndex_reg <= 12'h000;
		end else if (regWrEn) begin
			if (isAddr(regAddr, `ADDR_MIRROR_CTRL)) begin
				igmpSnoopEn_reg <= regWrData[`MIR_IGMP_BIT];
				ipv6SnoopMatchOption_reg <= regWrData[`MIR_MLDOPT_BIT];
				mldSnoopEn_reg <= regWrData[`MIR_MLD_BIT];
				sniffAndMode_reg <= regWrData[`MIR_SNIFF_BIT];
			end
			if (isAddr(regAddr, `ADDR_WRED_MAP)) begin
				redCode_reg <= regWrData[`WRED_RED_HI:`WRED_RED_LO];
				yellowCode_reg <= regWrData[`WRED_YEL_HI:`WRED_YEL_LO];
				greenCode_reg <= regWrData[`WRED_GRN_HI:`WRED_GRN_LO];
			end
			if (isAddr(regAddr, `ADDR_QUEUE_CTRL + 16'h0003)) begin
				twoQueuePriorityMap_reg <= regWrData[`QM_MAP_HI:`QM_MAP_LO];
				membershipDiscard_reg <= regWrData[`QM_DISCARD_BIT];
			end
			if (isAddr(regAddr, `ADDR_VLAN_INDEX))
				vlanIndex_reg[`VIDX_HI:8] <= regWrData[3:0];
			if (isAddr(regAddr, `ADDR_VLAN_INDEX + 16'h0001))
				vlanIndex_reg[7:0] <= regWrData;
		end
	end

	// staging registers: software writes, or a completed table read loads
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			entryValid_reg <= 1'b0;
			forwardOptionBit_reg <= 1'b0;
			entryPriority_reg <= 3'h0;
			spanningInstanceIndex_reg <= 3'h0;
			filterGroupId_reg <= 7'h00;
			untagMap_reg <= 7'h00;
			forwardMap_reg <= 7'h00;
		end else if (tableRdLoad) begin
			entryValid_reg <= tableRdWord0[`VE_VALID_BIT];
			forwardOptionBit_reg <= tableRdWord0[`VE_FO_BIT];
			entryPriority_reg <= tableRdWord0[`VE_PRIO_HI:`VE_PRIO_LO];
			spanningInstanceIndex_reg <=
				tableRdWord0[`VE_MSTP_HI:`VE_MSTP_LO];
			filterGroupId_reg <= tableRdWord0[`VE_FID_HI:`VE_FID_LO];
			untagMap_reg <= tableRdUntag;
			forwardMap_reg <= tableRdForward;
		end else if (regWrEn) begin
			if (isAddr(regAddr, `ADDR_VLAN_WORD0)) begin
				entryValid_reg <= regWrData[`VE_VALID_BIT-24];
				forwardOptionBit_reg <= regWrData[`VE_FO_BIT-24];
				entryPriority_reg <=
					regWrData[`VE_PRIO_HI-24:`VE_PRIO_LO-24];
			end
			if (isAddr(regAddr, `ADDR_VLAN_WORD0 + 16'h0002))
				spanningInstanceIndex_reg <=
					regWrData[`VE_MSTP_HI-8:`VE_MSTP_LO-8];
			if (isAddr(regAddr, `ADDR_VLAN_WORD0 + 16'h0003))
				filterGroupId_reg <= regWrData[`VE_FID_HI:`VE_FID_LO];
			if (isAddr(regAddr, `ADDR_VLAN_WORD1 + 16'h0003))
				untagMap_reg <= regWrData[`VE_MAP_HI:`VE_MAP_LO];
			if (isAddr(regAddr, `ADDR_VLAN_WORD2 + 16'h0003))
				forwardMap_reg <= regWrData[`VE_MAP_HI:`VE_MAP_LO];
		end
	end

	// action start: one strobe out, busy until the table engine is done
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			actionBusy_reg <= 1'b0;
			actionCode_reg <= `ACT_NOP;
			tableActionStrobe <= 1'b0;
			tableActionCode <= `ACT_NOP;
			tableIndex <= 12'h000;
		end else begin
			tableActionStrobe <= 1'b0;
			if (regWrEn && !actionBusy_reg &&
				isAddr(regAddr, `ADDR_VLAN_ACTION)) begin
				actionCode_reg <= regWrData[`ACT_CODE_HI:0];
				// a nop start finishes at once, nothing to wait for
				if (regWrData[`ACT_START_BIT] &&
					regWrData[`ACT_CODE_HI:0] != `ACT_NOP) begin
					actionBusy_reg <= 1'b1;
					tableActionStrobe <= 1'b1;
					tableActionCode <= regWrData[`ACT_CODE_HI:0];
					tableIndex <= vlanIndex_reg;
				end
			end else if (tableDone)
				actionBusy_reg <= 1'b0;
		end
	end

	snoop_classifier snoop (
		.igmpSnoopEn          (igmpSnoopEn_reg),
		.mldSnoopEn           (mldSnoopEn_reg),
		.ipv6SnoopMatchOption (ipv6SnoopMatchOption_reg),
		.frameIsIgmp          (frameIsIgmp),
		.frameIsIpv6          (frameIsIpv6),
		.nextHeader           (nextHeader),
		.hopNextHeader        (hopNextHeader),
		.toHost               (snoopHit)
	);

	mirror_queue_filter filter (
		.sniffAndMode        (sniffAndMode_reg),
		.ingressMirrorEn     (ingressMirrorEn),
		.srcPortMatch        (srcPortMatch),
		.dstPortMatch        (dstPortMatch),
		.twoQueuePriorityMap (twoQueuePriorityMap_reg),
		.regenPriority       (regenPriority),
		.membershipDiscard   (membershipDiscard_reg),
		.singleDest          (singleDest),
		.destPortMap         (destPortMap),
		.memberPortMap       (memberPortMap),
		.mirror              (mirrorHit),
		.highQueue           (queueHigh),
		.egressPortMap       (filteredMap),
		.dropFrame           (dropHit)
	);

	// one-cycle registered verdict per frame; verdict outputs hold between frames, wred codes follow the map register
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			resultValid <= 1'b0;
			toHost <= 1'b0;
			mirror <= 1'b0;
			highQueue <= 1'b0;
			egressPortMap <= 7'h00;
			dropFrame <= 1'b0;
			redCode <= `WRED_RED_RST;
			yellowCode <= `WRED_YEL_RST;
			greenCode <= `WRED_GRN_RST;
		end else begin
			resultValid <= frameValid;
			redCode <= redCode_reg;
			yellowCode <= yellowCode_reg;
			greenCode <= greenCode_reg;
			if (frameValid) begin
				toHost <= snoopHit;
				mirror <= mirrorHit;
				highQueue <= queueHigh;
				dropFrame <= dropHit;
				// forward option overrides the member-filtered destination map
				egressPortMap <= (vlanHit && forwardOptionBit_reg) ?
					forwardMap_reg : filteredMap;
			end
		end
	end
endmodule // switch_snoop_qos_vlan_regs
`default_nettype wire

// file: shared/switch_snoop_regs.vh
// register offsets, field positions and reset values of the global group
`ifndef SWITCH_SNOOP_REGS_VH
`define SWITCH_SNOOP_REGS_VH

`define ADDR_W             16
`define ADDR_MIRROR_CTRL   16'h0370
`define ADDR_WRED_MAP      16'h0378
`define ADDR_QUEUE_CTRL    16'h0390
`define ADDR_VLAN_WORD0    16'h0400
`define ADDR_VLAN_WORD1    16'h0404
`define ADDR_VLAN_WORD2    16'h0408
`define ADDR_VLAN_INDEX    16'h040c
`define ADDR_VLAN_ACTION   16'h040e

`define MIR_IGMP_BIT       6
`define MIR_MLDOPT_BIT     3
`define MIR_MLD_BIT        2
`define MIR_SNIFF_BIT      0

`define WRED_RED_HI        5
`define WRED_RED_LO        4
`define WRED_YEL_HI        3
`define WRED_YEL_LO        2
`define WRED_GRN_HI        1
`define WRED_GRN_LO        0
`define WRED_RED_RST       2'h3
`define WRED_YEL_RST       2'h2
`define WRED_GRN_RST       2'h1

`define QM_MAP_HI          7
`define QM_MAP_LO          6
`define QM_DISCARD_BIT     1
`define QM_MAP_RST         2'h2
`define QM_DISCARD_RST     1'b1
`define QMAP_P3_HIGH       2'h0
`define QMAP_UNUSED        2'h1
`define QMAP_P2_HIGH       2'h2
`define QMAP_P1_HIGH       2'h3

`define VE_VALID_BIT       31
`define VE_FO_BIT          27
`define VE_PRIO_HI         26
`define VE_PRIO_LO         24
`define VE_MSTP_HI         14
`define VE_MSTP_LO         12
`define VE_FID_HI          6
`define VE_FID_LO          0
`define VE_MAP_HI          6
`define VE_MAP_LO          0

`define VIDX_HI            11
`define ACT_START_BIT      7
`define ACT_CODE_HI        1
`define ACT_NOP            2'h0
`define ACT_WRITE          2'h1
`define ACT_READ           2'h2
`define ACT_CLEAR          2'h3

`define NH_HOPBYHOP        8'h00
`define NH_ICMPV4          8'h01
`define NH_ICMPV6          8'h3a
`define NH_ROUTING         8'h2b
`define NH_FRAGMENT        8'h2c
`define NH_ESP             8'h32
`define NH_AUTH            8'h33
`define NH_DESTOPT         8'h3c

`endif

// file: src/snoop_classifier.v
// decides whether an igmp or ipv6 frame is copied to the host port
`timescale 1ns/1ps
`default_nettype none
`include "switch_snoop_regs.vh"
module snoop_classifier (
	input  wire       igmpSnoopEn,
	input  wire       mldSnoopEn,
	input  wire       ipv6SnoopMatchOption,
	input  wire       frameIsIgmp,
	input  wire       frameIsIpv6,
	input  wire [7:0] nextHeader,
	input  wire [7:0] hopNextHeader,
	output wire       toHost
);
	function headerHit;
		input [7:0] nh;
		input       opt;
		begin
			if (opt)
				headerHit = (nh == `NH_ROUTING) || (nh == `NH_FRAGMENT) ||
					(nh == `NH_ESP) || (nh == `NH_AUTH) ||
					(nh == `NH_DESTOPT);
			else
				headerHit = (nh == `NH_ICMPV4) || (nh == `NH_ICMPV6);
		end
	endfunction

	wire mldHit;
	assign mldHit = headerHit(nextHeader, ipv6SnoopMatchOption) ||
		((nextHeader == `NH_HOPBYHOP) &&
		headerHit(hopNextHeader, ipv6SnoopMatchOption));
	assign toHost = (igmpSnoopEn & frameIsIgmp) |
		(mldSnoopEn & frameIsIpv6 & mldHit);
endmodule // snoop_classifier
`default_nettype wire

// file: src/mirror_queue_filter.v
// mirroring decision, two-queue mapping and membership restriction
`timescale 1ns/1ps
`default_nettype none
`include "switch_snoop_regs.vh"
module mirror_queue_filter (
	input  wire       sniffAndMode,
	input  wire       ingressMirrorEn,
	input  wire       srcPortMatch,
	input  wire       dstPortMatch,
	input  wire [1:0] twoQueuePriorityMap,
	input  wire [1:0] regenPriority,
	input  wire       membershipDiscard,
	input  wire       singleDest,
	input  wire [6:0] destPortMap,
	input  wire [6:0] memberPortMap,
	output wire       mirror,
	output reg        highQueue,
	output wire [6:0] egressPortMap,
	output wire       dropFrame
);
	wire filterHit;
	wire restrictMap;
	assign filterHit = sniffAndMode ? (srcPortMatch & dstPortMatch)
		: (srcPortMatch | dstPortMatch);
	// the global mode alone never mirrors
	assign mirror = ingressMirrorEn & filterHit;

	always @* begin
		case (twoQueuePriorityMap)
		`QMAP_P3_HIGH: highQueue = (regenPriority == 2'h3);
		`QMAP_P2_HIGH: highQueue = regenPriority[1];
		`QMAP_P1_HIGH: highQueue = (regenPriority != 2'h0);
		default:       highQueue = regenPriority[1]; // unused code, safe map
		endcase
	end

	assign restrictMap = membershipDiscard | ~singleDest;
	assign egressPortMap = restrictMap ? (destPortMap & memberPortMap)
		: destPortMap;
	// mirrored single-destination frames die on the membership check
	assign dropFrame = membershipDiscard & mirror & singleDest &
		((destPortMap & memberPortMap) == 7'h00);
endmodule // mirror_queue_filter
`default_nettype wire

// file: bench/switch_snoop_qos_vlan_regs_props.sv
// port-level checker of the snoop, qos and vlan staging register block
`timescale 1ns/1ps
`default_nettype none
`include "switch_snoop_regs.vh"
module switch_snoop_qos_vlan_regs_props (
	input wire logic               clk,
	input wire logic               rst,
	input wire logic [`ADDR_W-1:0] regAddr,
	input wire logic               regWrEn,
	input wire logic [7:0]         regWrData,
	input wire logic               regRdEn,
	input wire logic               regRdValid,
	input wire logic               frameValid,
	input wire logic               frameIsIgmp,
	input wire logic               frameIsIpv6,
	input wire logic               ingressMirrorEn,
	input wire logic               srcPortMatch,
	input wire logic               dstPortMatch,
	input wire logic               singleDest,
	input wire logic               resultValid,
	input wire logic               toHost,
	input wire logic               mirror,
	input wire logic               dropFrame,
	input wire logic               tableActionStrobe,
	input wire logic [1:0]         tableActionCode,
	input wire logic [31:0]        stageWord0,
	input wire logic [1:0]         redCode,
	input wire logic [1:0]         yellowCode,
	input wire logic [1:0]         greenCode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_rd_answer;
		regRdEn |=> regRdValid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_frame_answer;
		frameValid |=> resultValid ##1 (!resultValid || $past(frameValid));
	endproperty
	a_frame_answer: assert property (p_frame_answer) else $error("no verdict");
	property p_host_cause;
		resultValid && toHost |-> $past(frameIsIgmp || frameIsIpv6);
	endproperty
	a_host_cause: assert property (p_host_cause) else $error("host copy");
	property p_mirror_ingress;
		resultValid && mirror |-> $past(ingressMirrorEn);
	endproperty
	a_mirror_ingress: assert property (p_mirror_ingress) else $error("mir");
	property p_mirror_match;
		resultValid && mirror |-> $past(srcPortMatch || dstPortMatch);
	endproperty
	a_mirror_match: assert property (p_mirror_match) else $error("match");
	property p_mirror_both;
		resultValid && $past(ingressMirrorEn && srcPortMatch && dstPortMatch)
			|-> mirror;
	endproperty
	a_mirror_both: assert property (p_mirror_both) else $error("both");
	property p_drop_cause;
		resultValid && dropFrame |-> mirror && $past(singleDest);
	endproperty
	a_drop_cause: assert property (p_drop_cause) else $error("drop");
	property p_strobe_shape;
		tableActionStrobe |-> tableActionCode != `ACT_NOP ##1 !tableActionStrobe;
	endproperty
	a_strobe_shape: assert property (p_strobe_shape) else $error("stb");
	property p_strobe_cause;
		tableActionStrobe |-> $past(regWrEn && regWrData[`ACT_START_BIT] &&
			regAddr == `ADDR_VLAN_ACTION);
	endproperty
	a_strobe_cause: assert property (p_strobe_cause) else $error("start");
	property p_stage_reserved;
		stageWord0[30:28] == 3'h0 && stageWord0[23:15] == 9'h000 &&
			stageWord0[11:7] == 5'h00;
	endproperty
	a_stage_reserved: assert property (p_stage_reserved) else $error("rsv");
	property p_wred_hold;
		$changed({redCode, yellowCode, greenCode})
			|-> $past(regWrEn && regAddr == `ADDR_WRED_MAP, 1) ||
			$past(regWrEn && regAddr == `ADDR_WRED_MAP, 2);
	endproperty
	a_wred_hold: assert property (p_wred_hold) else $error("wred");
endmodule // switch_snoop_qos_vlan_regs_props
bind switch_snoop_qos_vlan_regs switch_snoop_qos_vlan_regs_props u_props (
	.clk, .rst, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdValid,
	.frameValid, .frameIsIgmp, .frameIsIpv6, .ingressMirrorEn, .srcPortMatch,
	.dstPortMatch, .singleDest, .resultValid, .toHost, .mirror, .dropFrame,
	.tableActionStrobe, .tableActionCode, .stageWord0, .redCode, .yellowCode,
	.greenCode);
`default_nettype wire

// file: bench/test_switch_snoop_qos_vlan_regs.sv
// self-checking bench of the snoop, qos and vlan staging register block
`timescale 1ns/1ps
`default_nettype none
`include "switch_snoop_regs.vh"
module test_switch_snoop_qos_vlan_regs;
	logic        clk, rst, regWrEn, regRdEn, tableDone, tableRdLoad, frameValid;
	logic        frameIsIgmp, frameIsIpv6, ingressMirrorEn, srcPortMatch;
	logic        dstPortMatch, singleDest, vlanHit;
	logic [15:0] regAddr, rnd, a, b;
	logic [7:0]  regWrData, nextHeader, hopNextHeader, mir, qm;
	logic [31:0] tableRdWord0;
	logic [6:0]  tableRdUntag, tableRdForward, destPortMap, memberPortMap;
	logic [6:0]  lookupPortMap, fwd;
	logic [1:0]  regenPriority;
	logic        fo;
	wire  [7:0]  regRdData;
	wire         regRdValid, tableActionStrobe, resultValid, toHost, mirror;
	wire         highQueue, dropFrame;
	wire  [1:0]  tableActionCode, redCode, yellowCode, greenCode;
	wire  [11:0] tableIndex;
	wire  [31:0] stageWord0;
	wire  [6:0]  stageUntag, stageForward, egressPortMap;
	int          bad_count, check_count, cycles;
	logic [15:0] regA [10] = '{16'h0370, 16'h0378, 16'h0390, 16'h0393,
		16'h0400, 16'h0401, 16'h0402, 16'h0403, 16'h0407, 16'h040b};
	logic [7:0]  rstV [10] = '{8'h00, 8'h39, 8'h00, 8'h82, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  wrV [10] = '{8'h4d, 8'h3f, 8'h00, 8'hc2, 8'h8f, 8'h00,
		8'h70, 8'h7f, 8'h7f, 8'h7f};
	logic [7:0]  nhTab [8] = '{8'h00, 8'h01, 8'h3a, 8'h2b, 8'h2c, 8'h32,
		8'h33, 8'h3c};
	switch_snoop_qos_vlan_regs uut (.clk, .rst, .regAddr, .regWrEn, .regWrData,
		.regRdEn, .regRdData, .regRdValid, .tableDone, .tableRdLoad,
		.tableRdWord0, .tableRdUntag, .tableRdForward, .tableActionStrobe,
		.tableActionCode, .tableIndex, .stageWord0, .stageUntag, .stageForward,
		.frameValid, .frameIsIgmp, .frameIsIpv6, .nextHeader, .hopNextHeader,
		.ingressMirrorEn, .srcPortMatch, .dstPortMatch, .regenPriority,
		.singleDest, .destPortMap, .memberPortMap, .vlanHit, .lookupPortMap,
		.resultValid, .toHost, .mirror, .highQueue, .egressPortMap, .dropFrame,
		.redCode, .yellowCode, .greenCode);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic nhm(input logic [7:0] n);
		if (mir[3])
			return n inside {8'h2b, 8'h2c, 8'h32, 8'h33, 8'h3c};
		return n == 8'h01 || n == 8'h3a;
	endfunction
	function automatic logic expHost();
		return (mir[6] && frameIsIgmp) || (mir[2] && frameIsIpv6 &&
			(nhm(nextHeader) || (nextHeader == 8'h00 && nhm(hopNextHeader))));
	endfunction
	function automatic logic expMirror();
		return ingressMirrorEn && (mir[0] ? srcPortMatch && dstPortMatch :
			srcPortMatch || dstPortMatch);
	endfunction
	function automatic logic expHigh();
		case (qm[7:6])
			2'h0: return regenPriority == 2'h3;
			2'h3: return regenPriority != 2'h0;
			default: return regenPriority[1];
		endcase
	endfunction
	function automatic logic [6:0] expEgress();
		if (vlanHit && fo)
			return fwd;
		return (qm[1] || !singleDest) ? destPortMap & memberPortMap :
			destPortMap;
	endfunction
	task automatic chk(input string nm, input logic [31:0] exp, got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic [15:0] ad, input logic [7:0] d);
		@(posedge clk);
		regAddr <= ad;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] ad, input logic [7:0] e);
		@(posedge clk);
		regAddr <= ad;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1;
		chk("regRdValid", 1, regRdValid);
		chk("regRdData", e, regRdData);
	endtask
	task automatic pulse(input int which);
		@(posedge clk);
		if (which == 0) tableDone <= 1'b1; else tableRdLoad <= 1'b1;
		@(posedge clk);
		tableDone <= 1'b0;
		tableRdLoad <= 1'b0;
	endtask
	// caller has set the frame fields at this same edge
	task automatic fire();
		frameValid <= 1'b1;
		@(posedge clk);
		frameValid <= 1'b0;
		#1;
		chk("resultValid", 1, resultValid);
		chk("toHost", expHost(), toHost);
		chk("mirror", expMirror(), mirror);
		chk("highQueue", expHigh(), highQueue);
		chk("egressPortMap", expEgress(), egressPortMap);
		chk("dropFrame", qm[1] && expMirror() && singleDest &&
			(destPortMap & memberPortMap) == 7'h00, dropFrame);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			test_done();
		end
	end
	initial begin
		rst = 1'b1;
		{regAddr, regWrEn, regRdEn, regWrData, tableDone, tableRdLoad} = '0;
		{tableRdWord0, tableRdUntag, tableRdForward, frameValid} = '0;
		{frameIsIgmp, frameIsIpv6, nextHeader, hopNextHeader} = '0;
		{ingressMirrorEn, srcPortMatch, dstPortMatch, regenPriority} = '0;
		{singleDest, destPortMap, memberPortMap, vlanHit, lookupPortMap} = '0;
		{fo, fwd} = '0;
		rnd = 16'h004a;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("wredCodes", 6'h39, {redCode, yellowCode, greenCode});
		for (int i = 0; i < 10; i++) rd(regA[i], rstV[i]);
		for (int i = 0; i < 10; i++) begin
			wr(regA[i], 8'hff);
			rd(regA[i], wrV[i]);
		end
		wr(16'h03f0, 8'hff);
		rd(16'h03f0, 8'h00);
		chk("stageWord0", 32'h8f00707f, stageWord0);
		chk("stageMaps", 14'h3fff, {stageUntag, stageForward});
		wr(`ADDR_WRED_MAP, 8'h1b);
		rd(`ADDR_WRED_MAP, 8'h1b);
		chk("wredCodes", 6'h1b, {redCode, yellowCode, greenCode});
		wr(16'h040c, 8'hfa);
		wr(16'h040d, 8'hbc);
		for (int k = 0; k < 4; k++) begin
			wr(`ADDR_VLAN_ACTION, 8'h80 | k[7:0]);
			#1;
			chk("tableActionStrobe", k != 0, tableActionStrobe);
			if (k == 0) continue;
			chk("tableAction", {k[1:0], 12'habc},
				{tableActionCode, tableIndex});
			rd(`ADDR_VLAN_ACTION, 8'h80 | k[7:0]);
			wr(`ADDR_VLAN_ACTION, 8'h81);
			#1;
			chk("tableActionStrobe", 0, tableActionStrobe);
			tableRdWord0 <= 32'h7aaad5d5;
			tableRdUntag <= 7'h2a;
			tableRdForward <= 7'h15;
			pulse(1);
			#1;
			chk("stageWord0", 32'h0a005055, stageWord0);
			chk("stageMaps", {7'h2a, 7'h15}, {stageUntag, stageForward});
			pulse(0);
			rd(`ADDR_VLAN_ACTION, k[7:0]);
		end
		mir = 8'h00;
		wr(`ADDR_MIRROR_CTRL, mir);
		for (int q = 0; q < 2; q++) begin
			qm = q ? 8'h00 : 8'h02;
			wr(16'h0393, qm);
			@(posedge clk);
			{ingressMirrorEn, srcPortMatch, singleDest} <= 3'h7;
			destPortMap <= 7'h01;
			memberPortMap <= 7'h7e;
			fire();
		end
		for (int f = 0; f < 2; f++) begin
			wr(16'h0400, f ? 8'h80 : 8'h88);
			wr(16'h040b, 8'h55);
			{fo, fwd} = {f == 0, 7'h55};
			@(posedge clk);
			{vlanHit, memberPortMap, destPortMap} <= {1'b1, 7'h7f, 7'h2a};
			fire();
		end
		// random traffic with a fresh global setting every sixth frame
		for (int i = 0; i < 60; i++) begin
			if (i % 6 == 0) begin
				rnd = lfsr(rnd);
				mir = rnd[7:0] & 8'h4d;
				qm = rnd[15:8] & 8'hc2;
				wr(`ADDR_MIRROR_CTRL, rnd[7:0]);
				wr(16'h0393, rnd[15:8]);
			end
			a = lfsr(rnd);
			b = lfsr(a);
			rnd = lfsr(b);
			@(posedge clk);
			{frameIsIgmp, frameIsIpv6, vlanHit} <= {a[0], a[1], 1'b0};
			nextHeader <= a[2] ? nhTab[a[5:3]] : a[15:8];
			hopNextHeader <= nhTab[a[8:6]];
			{ingressMirrorEn, srcPortMatch, dstPortMatch} <= {a[9] | a[10], a[12:11]};
			{regenPriority, singleDest} <= a[15:13];
			{destPortMap, memberPortMap} <= b[13:0];
			lookupPortMap <= rnd[6:0];
			fire();
		end
		test_done();
	end
endmodule // test_switch_snoop_qos_vlan_regs
`default_nettype wire
